/* tb/lsi_far_port.sv */
`timescale 1ns/1ps
// far port answering light with light after a turn-around; a cut fibre reads dark
module lsi_far_port #(
  parameter int ECHO_DLY = 3
)(
  input  wire logic clk_sys,
  input  wire logic fibre_ok,
  input  wire logic tx_light,
  output logic      rx_light
);
  logic [ECHO_DLY-1:0] seen;
  // follows our laser both on and off, so it also drops dark in our stop phase
  always_ff @(posedge clk_sys) begin
    seen <= {seen[ECHO_DLY-2:0], tx_light & fibre_ok};
  end
  assign rx_light = fibre_ok & seen[ECHO_DLY-1];
endmodule

/* tb/lsi_interlock_properties.sv */
`timescale 1ns/1ps
// port-level watch on the interlock state machine and laser enable
module lsi_interlock_properties
  import lsi_pkg::*;
#(
  parameter int RECHECK_CYC    = 200,
  parameter int PULSE_CYC_LOW  = 8,
  parameter int PULSE_CYC_HIGH = 10
)(
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       sig_detect,
  input wire logic [1:0] line_rate,
  input wire logic       dark_long,
  input wire logic       tx_enable,
  input wire logic       link_active,
  input wire logic       no_light,
  input wire logic [1:0] link_state
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  int hi_cnt, lo_cnt, next_hi, next_lo;
  // laser-on run and probing dark wait; cleared in reset so a long reset is not charged
  always_comb begin
    next_hi = tx_enable ? hi_cnt + 1 : 0;
    next_lo = (resetn && link_state == LSI_DISCONNECT && !tx_enable) ? lo_cnt + 1 : 0;
  end
  always_ff @(posedge clk_sys) begin
    hi_cnt <= next_hi;
    lo_cnt <= next_lo;
  end
  sequence lost_light_s;
    $fell(link_active);
  endsequence
  reset_state_a: assert property (disable iff (1'b0) !resetn |=> !tx_enable && no_light && link_state == 2'h1)
    else $error("reset outputs wrong");
  link_mode_a: assert property (link_active == (link_state == LSI_ACTIVE))
    else $error("link mode disagrees with state");
  shut_off_a: assert property (lost_light_s |-> !tx_enable && link_state == LSI_DISCONNECT ##[0:2] no_light)
    else $error("laser not off on leaving active");
  legal_step_a: assert property (link_state != $past(link_state) |->
    {$past(link_state), link_state} inside {4'h1, 4'h6, 4'hb, 4'h9, 4'hc, 4'hd}) else $error("illegal state step");
  active_entry_a: assert property ($rose(link_active) |-> $past(link_state) == LSI_RECONNECT)
    else $error("active without handshake");
  stop_dark_a: assert property (link_state == LSI_STOP |-> !tx_enable)
    else $error("laser on in stop phase");
  probe_width_a: assert property ($fell(tx_enable) && $past(link_state) == LSI_DISCONNECT |->
    hi_cnt == ((line_rate == 2'h0) ? PULSE_CYC_LOW : PULSE_CYC_HIGH)) else $error("probe width wrong");
  recheck_bound_a: assert property (lo_cnt <= RECHECK_CYC + 1)
    else $error("probe overdue");
endmodule

/* tb/lsi_interlock_tb.sv */
`timescale 1ns/1ps
`define CHK(a,b) begin checked++; if ((a) !== (b)) begin n_fail++; $display("CHECK FAILED %0t mismatch", $time); end end
`define WAITC(c,n) for (int w = 0; w < n && !(c); w++) @(negedge clk_sys); if (!(c)) begin n_fail++; results(); end
module lsi_interlock_tb;
  import lsi_pkg::*;
  logic       clk_sys, resetn, fibre_ok, dark_long, tx_enable, link_active, no_light, sig_detect, watch;
  logic [1:0] line_rate, link_state;
  int         n_fail, checked, hi;
  int         exp_q[$];
  event       note_ev;
  lsi_interlock #(.RECHECK_CYC(200), .PULSE_CYC_LOW(8), .PULSE_CYC_HIGH(10)) lsi_interlock_inst (
    .clk_sys(clk_sys), .resetn(resetn), .sig_detect(sig_detect), .line_rate(line_rate), .dark_long(dark_long),
    .tx_enable(tx_enable), .link_active(link_active), .no_light(no_light), .link_state(link_state));
  lsi_far_port lsi_far_port_inst (.clk_sys(clk_sys), .fibre_ok(fibre_ok), .tx_light(tx_enable), .rx_light(sig_detect));
  initial begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic results;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic note(input int v);
    exp_q.push_back(v);
    -> note_ev;
  endtask
  // probe widths are measured at each laser-off while watch is set, state notes compared on request
  always @(negedge clk_sys) begin
    if (watch && !tx_enable && hi > 0) `CHK(hi, exp_q.pop_front())
    hi = tx_enable ? hi + 1 : 0;
  end
  always @(note_ev) `CHK({no_light, link_active, tx_enable, link_state}, 5'(exp_q.pop_front()))
  initial begin
    void'($urandom(32'h0a5e));
    {resetn, fibre_ok, line_rate, dark_long, watch} = '0;
    repeat (5) @(negedge clk_sys);
    resetn = 1;
    note(5'h11);
    watch = 1;
    // every rate code with the fibre cut; two probes each
    for (int r = 0; r < 4; r++) begin
      line_rate = r[1:0];
      dark_long = 1'($urandom);
      exp_q.push_back(r == 0 ? 8 : 10);
      exp_q.push_back(r == 0 ? 8 : 10);
      `WAITC(exp_q.size() == 0, 1000)
    end
    watch = 0;
    $display("probe test done");
    fibre_ok = 1;
    `WAITC(link_active === 1'b1, 6000)
    note(5'h0c);
    $display("reconnect test done");
    repeat ($urandom_range(1, 60)) @(negedge clk_sys);
    fibre_ok = 0;
    `WAITC(tx_enable === 1'b0, 2000)
    @(negedge clk_sys);
    note(5'h11);
    $display("shutdown test done");
    fibre_ok = 1;
    `WAITC(link_active === 1'b1, 6000)
    resetn = 0;
    repeat (2) @(negedge clk_sys);
    note(5'h11);
    resetn = 1;
    repeat (2) @(negedge clk_sys);
    note(5'h11);
    @(negedge clk_sys);
    $display("reset test done");
    results();
  end
endmodule
bind lsi_interlock lsi_interlock_properties #(.RECHECK_CYC(RECHECK_CYC), .PULSE_CYC_LOW(PULSE_CYC_LOW),
  .PULSE_CYC_HIGH(PULSE_CYC_HIGH)) lsi_interlock_properties_inst (.clk_sys(clk_sys), .resetn(resetn),
  .sig_detect(sig_detect), .line_rate(line_rate), .dark_long(dark_long), .tx_enable(tx_enable),
  .link_active(link_active), .no_light(no_light), .link_state(link_state));

/* verilog/lsi_cfg.svh */
`ifndef LSI_CFG_SVH
`define LSI_CFG_SVH
// clock rate and line rate codes
`define LSI_CLK_HZ          40000000
`define LSI_RATE_266        2'h0
`define LSI_RATE_531        2'h1
`define LSI_RATE_1062       2'h2
// probe pulse width in us and derived cycles, per rate group
`define LSI_PULSE_US_LOW    154
`define LSI_PULSE_US_HIGH   618
`define LSI_PULSE_CYC_LOW   ((`LSI_PULSE_US_LOW * 40) )
`define LSI_PULSE_CYC_HIGH  ((`LSI_PULSE_US_HIGH * 40) )
// recheck period in ms and derived cycles
`define LSI_RECHECK_MS      10100
`define LSI_RECHECK_CYC     (`LSI_RECHECK_MS * 40000)
// no-light filter sample dividers and length
`define LSI_SAMP_DIV_SLOW   16'h0100
`define LSI_SAMP_DIV_FAST   16'h0000
`define LSI_FILT_LEN        4
`endif

/* verilog/lsi_interlock.sv */
`timescale 1ns/1ps
`include "lsi_cfg.svh"
// Summary of operation
// - raise no-light flag when receiver loses incoming light
// - on no-light, force transmitter off and start recheck timer
// - on recheck expiry, transmit for one probe pulse width
// - closed loop probe leads to handshake, then normal data
// - failed probe keeps transmitter off a further full recheck period
// - timer expiry or received light starts reconnect and resets timer
// - each port shuts its transmitter on its own no-light flag
// - resume data only after both directions and full handshake complete
// - transmitter off within bounded shutdown limit after a fault
// - while inactive, check link at the recheck period
// - transmitter on exactly one probe width during check or handshake; the master's verify pulse in reconnect is pulse_cyc - 1 cycles
// - transmitter off for the dark interval in the stop phase
// - timer constants selected by line rate; two higher rates share one
// - report link mode active or inactive
// - four-state machine: active, disconnect, stop, reconnect
// - no-light filter samples faster during reconnect sequence
// - dark interval is two or four probe widths by configuration

// notes for users of this block:
// the slow filter rate only guards the active link against glitches,
// so shutdown latency there is four slow samples plus one cycle.
// every state other than active belongs to the reconnect sequence and
// samples fast, since a probe lasts only one pulse width and the echo
// from the far port must be filtered well inside that window.
// the master flag records who started the attempt; a slave stays dark
// through the verify window and lights only on success.
// the stop phase counter saturates past the dark interval so that an
// indefinitely long stop phase cannot wrap and fake an early dark.
// line rate and dark length are levels; changing them mid-handshake
// only moves the end points of the running interval.
module lsi_interlock
  import lsi_pkg::*;
#(
  parameter int RECHECK_CYC    = `LSI_RECHECK_CYC,
  parameter int PULSE_CYC_LOW  = `LSI_PULSE_CYC_LOW,
  parameter int PULSE_CYC_HIGH = `LSI_PULSE_CYC_HIGH
)(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       sig_detect,
  input  wire logic [1:0] line_rate,
  input  wire logic       dark_long,
  output logic            tx_enable,
  output logic            link_active,
  output logic            no_light,
  output logic [1:0]      link_state
);
  lsi_state_t  state;
  lsi_state_t  next_state;
  logic [31:0] period_cnt;
  logic [31:0] next_period_cnt;
  logic [31:0] phase_cnt;
  logic [31:0] next_phase_cnt;
  logic        pulsing;
  logic        next_pulsing;
  logic        master;
  logic        next_master;
  logic        next_tx_enable;
  logic        flag;
  logic [31:0] pulse_cyc;
  logic [31:0] dark_cyc;

  // true outside normal operation, for the fast filter
  // probing, stop and verify all need the echo seen within one pulse
  function automatic logic in_handshake(input lsi_state_t s);
    return (s != LSI_ACTIVE);
  endfunction

  lsi_light_filter u_filter (
    .clk_sys       (clk_sys),
    .resetn        (resetn),
    .fast          (in_handshake(state)),
    .sig_detect    (sig_detect),
    .no_light_flag (flag)
  );

  // probe width by rate; 531 and 1062 share the longer value
  always_comb begin
    pulse_cyc = (line_rate == `LSI_RATE_266) ? PULSE_CYC_LOW : PULSE_CYC_HIGH;
    dark_cyc  = dark_long ? (pulse_cyc << 2) : (pulse_cyc << 1);
  end

  // state sequencing and timers
  always_comb begin
    next_state      = state;
    next_period_cnt = period_cnt;
    next_phase_cnt  = phase_cnt + 32'h1;
    next_pulsing    = pulsing;
    next_master     = master;
    next_tx_enable  = 1'b0;
    unique case (state)
      LSI_ACTIVE: begin
        next_tx_enable = 1'b1;
        if (flag) begin
          // shutdown takes one cycle after the filtered flag
          next_state      = LSI_DISCONNECT;
          next_tx_enable  = 1'b0;
          next_period_cnt = 32'h0;
          next_pulsing    = 1'b0;
        end
      end
      LSI_DISCONNECT: begin
        if (!pulsing) begin
          next_period_cnt = period_cnt + 32'h1;
          if (!flag) begin
            // light from far end: answer as slave and restart the timer
            next_master     = 1'b0;
            next_pulsing    = 1'b1;
            next_phase_cnt  = 32'h0;
            next_period_cnt = 32'h0;
            next_tx_enable  = 1'b1;
          end else if (period_cnt >= RECHECK_CYC - 1) begin
            next_master     = 1'b1;
            next_pulsing    = 1'b1;
            next_phase_cnt  = 32'h0;
            next_period_cnt = 32'h0;
            next_tx_enable  = 1'b1;
          end
        end else begin
          next_tx_enable = 1'b1;
          if (phase_cnt >= pulse_cyc - 1) begin
            next_tx_enable = 1'b0;
            next_pulsing   = 1'b0;
            next_phase_cnt = 32'h0;
            // light seen at probe end means the loop is closed
            if (!flag)
              next_state = LSI_STOP;
            else
              next_period_cnt = 32'h0;
          end
        end
      end
      LSI_STOP: begin
        // stay dark; early loss of light proves the far end also stopped
        // saturate so a very long stop phase cannot wrap below dark_cyc
        if (phase_cnt >= dark_cyc)
          next_phase_cnt = phase_cnt;
        if (flag) begin
          next_phase_cnt = 32'h0;
          if (phase_cnt < dark_cyc)
            next_state = LSI_RECONNECT;
          else begin
            next_state      = LSI_DISCONNECT;
            next_period_cnt = 32'h0;
          end
        end
      end
      LSI_RECONNECT: begin
        // wait out the dark interval before verifying
        next_tx_enable = master && (phase_cnt >= dark_cyc);
        if (phase_cnt >= dark_cyc + pulse_cyc - 1) begin
          next_phase_cnt  = 32'h0;
          next_period_cnt = 32'h0;
          if (!flag) begin
            next_state     = LSI_ACTIVE;
            next_tx_enable = 1'b1;
          end else begin
            next_state     = LSI_DISCONNECT;
            next_tx_enable = 1'b0;
          end
        end
      end
    endcase
  end

  // registers; reset lands in dark probing
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      state       <= LSI_DISCONNECT;
      period_cnt  <= 32'h0;
      phase_cnt   <= 32'h0;
      pulsing     <= 1'b0;
      master      <= 1'b0;
      tx_enable   <= 1'b0;
      link_active <= 1'b0;
      no_light    <= 1'b1;
      link_state  <= 2'h1;
    end else begin
      state       <= next_state;
      period_cnt  <= next_period_cnt;
      phase_cnt   <= next_phase_cnt;
      pulsing     <= next_pulsing;
      master      <= next_master;
      tx_enable   <= next_tx_enable;
      link_active <= (next_state == LSI_ACTIVE);
      no_light    <= flag;
      link_state  <= next_state;
    end
  end
endmodule

/* verilog/lsi_light_filter.sv */
`timescale 1ns/1ps
`include "lsi_cfg.svh"
// integrating filter on the signal-detect input
module lsi_light_filter
  import lsi_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic fast,
  input  wire logic sig_detect,
  output logic      no_light_flag
);
  logic [15:0] div;
  logic [15:0] next_div;
  logic [`LSI_FILT_LEN-1:0] hist;
  logic [`LSI_FILT_LEN-1:0] next_hist;
  logic        next_flag;

  // sample tick; faster while reconnecting so the handshake sees light changes in time
  always_comb begin
    next_div  = div + 16'h0001;
    next_hist = hist;
    next_flag = no_light_flag;
    if (div >= (fast ? `LSI_SAMP_DIV_FAST : `LSI_SAMP_DIV_SLOW)) begin
      next_div  = 16'h0000;
      next_hist = {hist[`LSI_FILT_LEN-2:0], ~sig_detect};
      // flag changes only on a full run of agreeing samples
      if (&next_hist)
        next_flag = 1'b1;
      else if (~|next_hist)
        next_flag = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      div           <= 16'h0000;
      hist          <= '1;
      no_light_flag <= 1'b1;
    end else begin
      div           <= next_div;
      hist          <= next_hist;
      no_light_flag <= next_flag;
    end
  end
endmodule

/* verilog/lsi_pkg.sv */
package lsi_pkg;
  typedef enum logic [1:0] {
    LSI_ACTIVE     = 2'b00,
    LSI_DISCONNECT = 2'b01,
    LSI_STOP       = 2'b10,
    LSI_RECONNECT  = 2'b11
  } lsi_state_t;
endpackage
